// ==== srblu_defines.svh ====
// Constants for the shift-right and bitwise logic unit: widths, limits and reset values.
// Assumes it is included by its bare name from the package and from every module.
// Functional notes
// [RQ1] Immediate shift gives operand shifted right arithmetically.
// [RQ2] Vacated high bits copy the sign bit.
// [RQ3] Issuer keeps immediate shift amount within 0..31; the issuer model passes larger amounts through when wide_ok_in is set.
// [RQ4] AND gives bitwise conjunction of both operands.
// [RQ5] AND-inverse ANDs first with complemented second.
// [RQ6] Inversion gives complement of first operand.
// [RQ7] OR gives bitwise disjunction of both operands.
// [RQ8] No guard means destination always written; the unit drops the write of an immediate shift whose amount is above 31.
// [RQ9] Guard bit zero one enables the write.
// [RQ10] Guard bit zero zero keeps destination unchanged.
// [RQ11] Operands and results are 32 bits, bit 31 sign.
// [RQ12] Shift amount zero returns operand unchanged.
`ifndef SRBLU_DEFINES_SVH
`define SRBLU_DEFINES_SVH

`define SRBLU_DATA_W 32
`define SRBLU_SIGN_BIT 31
`define SRBLU_MOD_W 7
`define SRBLU_SHAMT_W 5
`define SRBLU_SHAMT_MAX 7'h1f
`define SRBLU_GUARD_BIT 0
`define SRBLU_RESULT_RST 32'h00000000
`define SRBLU_REG_DEPTH 128
`define SRBLU_REG_ADDR_W 7

`endif

// ==== srblu_pkg.sv ====
// Types shared by the shift-right and bitwise logic unit, its issue model and its bench.
// Assumes the defines header is on the include path.
`include "srblu_defines.svh"

package srblu_pkg;

    typedef logic [`SRBLU_DATA_W-1:0] srblu_word_t;

    typedef enum logic [2:0] {
        SRBLU_OP_ASRI,
        SRBLU_OP_AND,
        SRBLU_OP_ANDINV,
        SRBLU_OP_INV,
        SRBLU_OP_OR
    } srblu_op_t;

endpackage

// ==== srblu_regfile.sv ====
// Destination register store: one write port and one registered read port.
// Assumes a single clock and a synchronous active-high reset from the pipeline.
`timescale 1ns/1ps
`include "srblu_defines.svh"

module srblu_regfile #(
    parameter int DATA_W = `SRBLU_DATA_W,
    parameter int DEPTH = `SRBLU_REG_DEPTH,
    parameter int ADDR_W = `SRBLU_REG_ADDR_W
) (
    input wire logic clk_sys_in, // System clock.
    input wire logic rst_in, // Synchronous reset, active high.
    input wire logic wr_en_in, // Write strobe.
    input wire logic [ADDR_W-1:0] wr_addr_in, // Write index.
    input wire logic [DATA_W-1:0] wr_data_in, // Write data.
    input wire logic [ADDR_W-1:0] rd_addr_in, // Read index.
    output logic [DATA_W-1:0] rd_data_out // Registered read data.
);

    logic [DATA_W-1:0] mem_reg [DEPTH];
    logic [DATA_W-1:0] rd_data_reg;

    // Contents are not cleared by reset; software must write before reading.
    always_ff @(posedge clk_sys_in)
    begin
        if (wr_en_in)
        begin
            mem_reg[wr_addr_in] <= wr_data_in;
        end
    end

    // A read of the entry being written returns the old value.
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            rd_data_reg <= '0;
        end
        else
        begin
            rd_data_reg <= mem_reg[rd_addr_in];
        end
    end

    assign rd_data_out = rd_data_reg;

endmodule

// ==== srblu_unit.sv ====
// Single-stage shift-right and bitwise logic unit with guarded destination write.
// Assumes operands, opcode and guard arrive synchronous to clk_sys_in from issue logic.
`timescale 1ns/1ps
`include "srblu_defines.svh"

module srblu_unit #(
    parameter int DEPTH = `SRBLU_REG_DEPTH,
    parameter int ADDR_W = `SRBLU_REG_ADDR_W
) (
    input wire logic clk_sys_in, // System clock, 20 MHz.
    input wire logic rst_in, // Synchronous reset, active high.
    input wire logic issue_valid_in, // Operation issued this cycle.
    input wire srblu_pkg::srblu_op_t op_in, // Operation select.
    input wire srblu_pkg::srblu_word_t first_source_operand_in, // First operand.
    input wire srblu_pkg::srblu_word_t second_source_operand_in, // Second operand.
    input wire logic [`SRBLU_MOD_W-1:0] shift_amount_in, // Immediate shift amount.
    input wire logic guard_present_in, // A guard register is supplied.
    input wire srblu_pkg::srblu_word_t guard_value_in, // Guard register value.
    input wire logic [ADDR_W-1:0] dest_index_in, // Destination register index.
    input wire logic [ADDR_W-1:0] read_index_in, // Register store read index.
    output logic result_valid_out, // Result computed, one-cycle pulse.
    output srblu_pkg::srblu_word_t result_out, // Computed result, registered.
    output logic write_enable_out, // Destination write, one-cycle pulse.
    output logic [ADDR_W-1:0] dest_index_out, // Destination index, registered.
    output logic shift_range_error_out, // Shift amount above 31, pulse.
    output srblu_pkg::srblu_word_t read_data_out // Register store read data.
);

    import srblu_pkg::*;

    srblu_word_t result_next;
    srblu_word_t result_reg;
    logic result_valid_reg;
    logic write_enable_next;
    logic write_enable_reg;
    logic [ADDR_W-1:0] dest_index_reg;
    logic shift_range_error_next;
    logic shift_range_error_reg;
    logic op_known;
    logic [`SRBLU_SHAMT_W-1:0] shamt;

    assign shamt = shift_amount_in[`SRBLU_SHAMT_W-1:0];

    // A shift amount above 31 is the issuer's fault; it is flagged and its write is dropped.
    assign shift_range_error_next = issue_valid_in && (op_in == SRBLU_OP_ASRI)
        && (shift_amount_in > `SRBLU_SHAMT_MAX); // RQ3

    always_comb
    begin
        result_next = `SRBLU_RESULT_RST;
        op_known = 1'b1;
        case (op_in)
            SRBLU_OP_ASRI:
            begin
                // Signed shift fills from bit 31; a zero amount passes the operand through.
                result_next = srblu_word_t'($signed(first_source_operand_in) >>> shamt); // RQ1 RQ2 RQ12
            end
            SRBLU_OP_AND:
            begin
                result_next = first_source_operand_in & second_source_operand_in; // RQ4
            end
            SRBLU_OP_ANDINV:
            begin
                result_next = first_source_operand_in & ~second_source_operand_in; // RQ5
            end
            SRBLU_OP_INV:
            begin
                result_next = ~first_source_operand_in; // RQ6
            end
            SRBLU_OP_OR:
            begin
                result_next = first_source_operand_in | second_source_operand_in; // RQ7
            end
            default:
            begin
                op_known = 1'b0;
            end
        endcase
    end

    // Only the guard's lowest bit is looked at; the rest of the word is ignored.
    always_comb
    begin
        write_enable_next = 1'b0;
        if (issue_valid_in && op_known && !shift_range_error_next)
        begin
            if (!guard_present_in)
            begin
                write_enable_next = 1'b1; // RQ8
            end
            else
            begin
                write_enable_next = guard_value_in[`SRBLU_GUARD_BIT]; // RQ9 RQ10
            end
        end
    end

    // The result is computed even when the guard discards it, so it can be observed.
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            result_reg <= `SRBLU_RESULT_RST;
            dest_index_reg <= '0;
        end
        else if (issue_valid_in)
        begin
            result_reg <= result_next; // RQ11
            dest_index_reg <= dest_index_in;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            result_valid_reg <= 1'b0;
            write_enable_reg <= 1'b0;
            shift_range_error_reg <= 1'b0;
        end
        else
        begin
            result_valid_reg <= issue_valid_in && op_known;
            write_enable_reg <= write_enable_next;
            shift_range_error_reg <= shift_range_error_next;
        end
    end

    // A disabled write leaves the stored destination untouched.
    srblu_regfile #(
        .DATA_W(`SRBLU_DATA_W),
        .DEPTH(DEPTH),
        .ADDR_W(ADDR_W)
    ) u_regfile (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .wr_en_in(write_enable_reg), // RQ10
        .wr_addr_in(dest_index_reg),
        .wr_data_in(result_reg),
        .rd_addr_in(read_index_in),
        .rd_data_out(read_data_out)
    );

    assign result_out = result_reg;
    assign result_valid_out = result_valid_reg;
    assign write_enable_out = write_enable_reg;
    assign dest_index_out = dest_index_reg;
    assign shift_range_error_out = shift_range_error_reg;

    default clocking cb @(posedge clk_sys_in);
    endclocking

    default disable iff (rst_in);

    sequence s_asri_issue;
        issue_valid_in && op_in == SRBLU_OP_ASRI && shift_amount_in <= `SRBLU_SHAMT_MAX;
    endsequence

    property p_asri_value;
        s_asri_issue |=> result_out
            == srblu_word_t'($signed($past(first_source_operand_in)) >>> $past(shamt));
    endproperty
    a_asri_value: assert property (p_asri_value) else $error("asri result wrong"); // RQ1

    property p_asri_sign;
        s_asri_issue |=> result_out[`SRBLU_SIGN_BIT]
            == $past(first_source_operand_in[`SRBLU_SIGN_BIT]);
    endproperty
    a_asri_sign: assert property (p_asri_sign) else $error("asri sign not kept"); // RQ2

    property p_asri_zero;
        issue_valid_in && op_in == SRBLU_OP_ASRI && shift_amount_in == 7'h00
            |=> result_out == $past(first_source_operand_in);
    endproperty
    a_asri_zero: assert property (p_asri_zero) else $error("zero shift changed value"); // RQ12

    property p_range;
        issue_valid_in && op_in == SRBLU_OP_ASRI && shift_amount_in > `SRBLU_SHAMT_MAX
            |=> shift_range_error_out && !write_enable_out;
    endproperty
    a_range: assert property (p_range) else $error("range error not flagged"); // RQ3

    property p_and;
        issue_valid_in && op_in == SRBLU_OP_AND
            |=> result_out == ($past(first_source_operand_in) & $past(second_source_operand_in));
    endproperty
    a_and: assert property (p_and) else $error("and result wrong"); // RQ4

    property p_andinv;
        issue_valid_in && op_in == SRBLU_OP_ANDINV
            |=> (result_out & $past(second_source_operand_in)) == '0
            && (result_out | $past(second_source_operand_in))
            == ($past(first_source_operand_in) | $past(second_source_operand_in));
    endproperty
    a_andinv: assert property (p_andinv) else $error("and-inverse result wrong"); // RQ5

    property p_inv;
        issue_valid_in && op_in == SRBLU_OP_INV
            |=> (result_out ^ $past(first_source_operand_in)) == ~'0;
    endproperty
    a_inv: assert property (p_inv) else $error("inverse result wrong"); // RQ6

    property p_or;
        issue_valid_in && op_in == SRBLU_OP_OR
            |=> result_out == ($past(first_source_operand_in) | $past(second_source_operand_in));
    endproperty
    a_or: assert property (p_or) else $error("or result wrong"); // RQ7

    property p_unguarded;
        issue_valid_in && op_in != SRBLU_OP_ASRI && op_in <= SRBLU_OP_OR && !guard_present_in
            |=> write_enable_out && result_valid_out;
    endproperty
    a_unguarded: assert property (p_unguarded) else $error("unguarded write missing"); // RQ8

    property p_guard_true;
        issue_valid_in && op_in == SRBLU_OP_OR && guard_present_in
            && guard_value_in[`SRBLU_GUARD_BIT]
            |=> write_enable_out && dest_index_out == $past(dest_index_in);
    endproperty
    a_guard_true: assert property (p_guard_true) else $error("guarded write missing"); // RQ9

    property p_guard_false;
        issue_valid_in && guard_present_in && !guard_value_in[`SRBLU_GUARD_BIT]
            |=> !write_enable_out;
    endproperty
    a_guard_false: assert property (p_guard_false) else $error("write despite false guard"); // RQ10

    property p_idle;
        !issue_valid_in |=> !write_enable_out && !result_valid_out;
    endproperty
    a_idle: assert property (p_idle) else $error("write without issue"); // RQ8

    c_asri_neg: cover property (s_asri_issue and first_source_operand_in[`SRBLU_SIGN_BIT]);
    c_guard_false: cover property (issue_valid_in && guard_present_in
        && !guard_value_in[`SRBLU_GUARD_BIT]);
    c_back_to_back: cover property (issue_valid_in ##1 issue_valid_in);
    c_range: cover property (shift_range_error_out);

endmodule

// ==== srblu_issuer.sv ====
// Issue-side model: forwards operations from the bench to the logic unit.
// Assumes the bench changes its request lines just after the rising clock edge.
`timescale 1ns/1ps
`include "srblu_defines.svh"

module srblu_issuer (
    input wire logic valid_in, // Request valid.
    input wire srblu_pkg::srblu_op_t op_in, // Requested operation.
    input wire srblu_pkg::srblu_word_t a_in, // First operand.
    input wire srblu_pkg::srblu_word_t b_in, // Second operand.
    input wire logic [`SRBLU_MOD_W-1:0] shift_in, // Requested shift amount.
    input wire logic wide_ok_in, // Lets an out-of-range shift through.
    output logic issue_valid_out, // Issue qualifier.
    output srblu_pkg::srblu_op_t op_out, // Issued operation.
    output srblu_pkg::srblu_word_t first_out, // Issued first operand.
    output srblu_pkg::srblu_word_t second_out, // Issued second operand.
    output logic [`SRBLU_MOD_W-1:0] shift_out // Issued shift amount.
);
    import srblu_pkg::*;

    // Idle operand lines carry the inverse of the request, so a unit that
    // samples them without a qualifier picks up garbage rather than a match.
    assign issue_valid_out = valid_in;
    assign op_out = op_in;
    assign first_out = valid_in ? a_in : ~a_in;
    assign second_out = valid_in ? b_in : ~b_in;
    assign shift_out = wide_ok_in ? shift_in : {2'b00, shift_in[4:0]};
endmodule

// ==== test_srblu_unit.sv ====
// Self-checking bench for the shift-right and bitwise logic unit.
// Assumes the issue model forwards requests and the store holds 128 entries.
`timescale 1ns/1ps
`include "srblu_defines.svh"

module test_srblu_unit;
    import srblu_pkg::*;
    logic clk_sys_in = 1'b0, rst_in = 1'b1, started = 1'b0;
    logic req_valid = 1'b0, wide_ok = 1'b0, gp = 1'b0, allow_wide = 1'b0;
    srblu_op_t req_op = SRBLU_OP_AND;
    srblu_word_t req_a = 32'h0, req_b = 32'h0, gv = 32'h0;
    logic [6:0] req_sh = 7'h0, dest = 7'h0, rd_idx = 7'h0;
    logic issue_valid, res_valid, we, rerr;
    srblu_op_t op;
    srblu_word_t a, b, res, rd_data;
    logic [6:0] sh, dest_o;
    logic exp_val = 1'b0, exp_we = 1'b0, exp_err = 1'b0, rd_chk = 1'b0;
    logic q_val = 1'b0, q_we = 1'b0, q_err = 1'b0, q_rchk = 1'b0;
    srblu_word_t exp_res = 32'h0, q_res = 32'h0, rd_exp = 32'h0, q_rexp = 32'h0;
    logic [6:0] exp_dest = 7'h0, q_dest = 7'h0;
    srblu_word_t mem_exp [128];
    logic known [128];
    int n_fail = 0, comparisons = 0, cycles = 0;

    srblu_issuer i_issuer (.valid_in(req_valid), .op_in(req_op), .a_in(req_a), .b_in(req_b),
        .shift_in(req_sh), .wide_ok_in(wide_ok), .issue_valid_out(issue_valid),
        .op_out(op), .first_out(a), .second_out(b), .shift_out(sh));

    srblu_unit i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .issue_valid_in(issue_valid),
        .op_in(op), .first_source_operand_in(a), .second_source_operand_in(b),
        .shift_amount_in(sh), .guard_present_in(gp), .guard_value_in(gv),
        .dest_index_in(dest), .read_index_in(rd_idx), .result_valid_out(res_valid),
        .result_out(res), .write_enable_out(we), .dest_index_out(dest_o),
        .shift_range_error_out(rerr), .read_data_out(rd_data));

    initial
    begin
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    function automatic srblu_word_t calc(srblu_op_t o, srblu_word_t x, y, logic [6:0] s);
        case (o)
            SRBLU_OP_ASRI: calc = $signed(x) >>> s[4:0];
            SRBLU_OP_AND: calc = x & y;
            SRBLU_OP_ANDINV: calc = x & ~y;
            SRBLU_OP_INV: calc = ~x;
            SRBLU_OP_OR: calc = x | y;
            default: calc = 32'h0;
        endcase
    endfunction

    task automatic cmp(input string name, input logic [31:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic issue(input srblu_op_t o, input srblu_word_t x, y, input logic [6:0] s,
        input logic g, input srblu_word_t gval, input logic [6:0] d);
        logic [6:0] sc;
        logic kn, wr;
        sc = (s > 7'h1f && !allow_wide) ? {2'b00, s[4:0]} : s;
        kn = o <= SRBLU_OP_OR;
        wr = kn && !(o == SRBLU_OP_ASRI && sc > 7'h1f) && (!g || gval[0]);
        @(posedge clk_sys_in);
        // The pass-through permission travels with its own request, never ahead of it.
        wide_ok <= allow_wide;
        req_valid <= 1'b1;
        req_op <= o;
        req_a <= x;
        req_b <= y;
        req_sh <= s;
        gp <= g;
        gv <= gval;
        dest <= d;
        exp_val <= kn;
        exp_we <= wr;
        exp_err <= o == SRBLU_OP_ASRI && sc > 7'h1f;
        exp_res <= calc(o, x, y, sc);
        exp_dest <= d;
        if (wr)
        begin
            mem_exp[d] = calc(o, x, y, sc);
            known[d] = 1'b1;
        end
    endtask

    task automatic idle();
        @(posedge clk_sys_in);
        req_valid <= 1'b0;
        exp_val <= 1'b0;
        exp_we <= 1'b0;
        exp_err <= 1'b0;
    endtask

    // Expectations pass through one register stage to line up with the unit.
    always @(posedge clk_sys_in)
    begin
        started <= 1'b1;
        {q_val, q_we, q_err, q_res, q_dest} <= {exp_val, exp_we, exp_err, exp_res, exp_dest};
        {q_rchk, q_rexp} <= {rd_chk, rd_exp};
        cycles++;
        if (cycles == 2000)
        begin
            n_fail++;
            summarize();
        end
    end

    always @(negedge clk_sys_in)
    begin
        if (started)
        begin
            cmp("result_valid", q_val, res_valid);
            cmp("write_enable", q_we, we);
            cmp("range_error", q_err, rerr);
            cmp("result", q_res, res);
            cmp("dest_index", q_dest, dest_o);
            if (q_rchk)
                cmp("read_data", q_rexp, rd_data);
        end
    end

    task automatic summarize();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        logic [6:0] shl [6];
        srblu_word_t src [6];
        shl = '{7'h00, 7'h01, 7'h02, 7'h1f, 7'h04, 7'h1f};
        src = '{32'h7008000f, 32'h7008000f, 32'h7008000f, 32'h7008000f, 32'h80030007,
            32'h80030007};
        foreach (known[i])
            known[i] = 1'b0;
        void'($urandom(62));
        // Documented examples pin the reference model down independently of the unit.
        cmp("r_asri1", 32'h38040007, calc(SRBLU_OP_ASRI, 32'h7008000f, 32'h0, 7'h1));
        cmp("r_asri4", 32'hf8003000, calc(SRBLU_OP_ASRI, 32'h80030007, 32'h0, 7'h4));
        cmp("r_asri31", 32'hffffffff, calc(SRBLU_OP_ASRI, 32'h80030007, 32'h0, 7'h1f));
        cmp("r_and", 32'hf3100000, calc(SRBLU_OP_AND, 32'hf310ffff, 32'hffff0000, 7'h0));
        cmp("r_ai", 32'h0000ffff, calc(SRBLU_OP_ANDINV, 32'hf310ffff, 32'hffff0000, 7'h0));
        cmp("r_inv", 32'h0cef0000, calc(SRBLU_OP_INV, 32'hf310ffff, 32'h0, 7'h0));
        cmp("r_or", 32'hfb98ffff, calc(SRBLU_OP_OR, 32'hf310ffff, 32'h88888888, 7'h0));
        repeat (6) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        foreach (shl[i])
            issue(SRBLU_OP_ASRI, src[i], 32'h0, shl[i], 1'b0, 32'h0, 7'(i + 1));
        for (int k = 1; k <= 4; k++)
            issue(srblu_op_t'(k), 32'hf310ffff, 32'hffff0000, 7'h0, 1'b0, 32'h0, 7'(k + 10));
        // Guard with bit 1 set but bit 0 clear must still block the write.
        issue(SRBLU_OP_AND, 32'h0, 32'h0, 7'h0, 1'b1, 32'h2, 7'h01);
        issue(SRBLU_OP_OR, 32'h88888888, 32'h1, 7'h0, 1'b1, 32'h1, 7'h14);
        allow_wide = 1'b1;
        issue(SRBLU_OP_ASRI, 32'h80030007, 32'h0, 7'h40, 1'b0, 32'h0, 7'h02);
        issue(SRBLU_OP_ASRI, 32'h80030007, 32'h0, 7'h25, 1'b0, 32'h0, 7'h03);
        allow_wide = 1'b0;
        for (int k = 5; k <= 7; k++)
            issue(srblu_op_t'(k), 32'hffffffff, 32'h1, 7'h0, 1'b0, 32'h0, 7'h04);
        repeat (300)
            issue(srblu_op_t'($urandom_range(7, 0)), $urandom, $urandom, 7'($urandom),
                1'($urandom), $urandom, 7'($urandom));
        repeat (2) idle();
        for (int i = 0; i < 128; i++)
        begin
            @(posedge clk_sys_in);
            rd_idx <= 7'(i);
            rd_chk <= known[i];
            rd_exp <= mem_exp[i];
        end
        // Let the last entry's check stand for one edge before it is withdrawn.
        @(posedge clk_sys_in);
        rd_chk <= 1'b0;
        repeat (3) @(posedge clk_sys_in);
        summarize();
    end
endmodule
